// [hw/opis_slave.sv]
// Serial register slave of the digitally pulled oscillator, with core timing.
// Assumes an external serial master on scl_i/sda_i and link_clk far above SCL.
//
// Functional notes
// - Writable 4-bit pull range field, bits 3:0
// - Decode range code into pull span
// - Range bits 15:4 read zero, writes ignored
// - Range loads factory strap, later overwritable
// - Slave only, serial clock up to 1 MHz
// - Data line stable while clock high
// - Detect START and STOP conditions
// - Repeated START begins a new transaction
// - Bytes of 8 bits, MSB first, unlimited
// - Receiver acknowledges on the ninth clock
// - NACK only on device address mismatch
// - Read NACK sends next byte
// - 7-bit address, direction 0 read, 1 write
// - 8-bit register pointer follows device address
// - Pointer auto-increments, wraps 255 to 0
// - Registers are 16 bits, MSB byte first
// - Frequency change starts 22 us later
// - Settling flagged for 30 us after change
// - 26-bit pull value in regs 0 and 1, reset zero
// - Only upper word write starts a change
// - Reg 1 bit 10 software output enable
`timescale 1ns/10ps
`include "opis_defines.svh"

module opis_slave
    import opis_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR   = `OPIS_DEV_ADDR_DFLT,
    parameter int         FDELAY_CYC = `OPIS_FDELAY_CYC,
    parameter int         SETTLE_CYC = `OPIS_SETTLE_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        link_clk,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output      logic        sda_o,
    output      logic        sda_oe,
    input  wire logic [3:0]  range_strap,
    input  wire logic        oe_hw_sel,
    input  wire logic        oe_pin,
    output      logic [25:0] pull_value_o,
    output      logic [3:0]  pull_range_o,
    output      logic [13:0] pull_span_o,
    output      logic        drv_enable_o,
    output      logic        freq_change_o,
    output      logic        settling_o
);

    // Span in quarter-ppm units
    function automatic logic [13:0] span_of(input logic [3:0] code);
        case (code)
            4'h0:    span_of = 14'h0019;
            4'h1:    span_of = 14'h0028;
            4'h2:    span_of = 14'h0032;
            4'h3:    span_of = 14'h0064;
            4'h4:    span_of = 14'h00C8;
            4'h5:    span_of = 14'h0140;
            4'h6:    span_of = 14'h0190;
            4'h7:    span_of = 14'h01F4;
            4'h8:    span_of = 14'h0258;
            4'h9:    span_of = 14'h0320;
            4'hA:    span_of = 14'h0640;
            4'hB:    span_of = 14'h0960;
            4'hC:    span_of = 14'h0C80;
            4'hD:    span_of = 14'h12C0;
            4'hE:    span_of = 14'h1900;
            default: span_of = 14'h3200;
        endcase
    endfunction

    function automatic logic [15:0] rd_word(input opis_link_t s, input logic [7:0] p);
        case (p)
            `OPIS_REG_LOWER: rd_word = s.lower;
            `OPIS_REG_UPPER: rd_word = {5'h00, s.oe, s.upper};
            `OPIS_REG_RANGE: rd_word = {12'h000, s.range};
            default:         rd_word = 16'h0000;
        endcase
    endfunction

    // Link reset: rst carried into the link domain
    logic       lrst_s1;
    logic       lrst;
    logic [5:0] lin_f;
    logic       scl_f;
    logic       sda_f;
    logic [3:0] strap_f;

    always_ff @(posedge link_clk)
    begin
        lrst_s1 <= rst;
        lrst    <= lrst_s1;
    end

    opis_sync #(.W(6), .RST_VAL(6'h03)) u_lsync (
        .clk (link_clk),
        .rst (lrst),
        .d   ({range_strap, scl_i, sda_i}),
        .q   (lin_f)
    );

    assign scl_f   = lin_f[1];
    assign sda_f   = lin_f[0];
    assign strap_f = lin_f[5:2];

    opis_link_t  l_q;
    opis_link_t  l_d;
    logic        scl_rise;
    logic        scl_fall;
    logic        start;
    logic        stop;
    logic        wr_en;
    logic        upd;
    logic        chg;
    logic [15:0] word;

    assign scl_rise   = scl_f & ~l_q.scl_p;
    assign scl_fall   = ~scl_f & l_q.scl_p;
    assign start      = scl_f & l_q.scl_p & l_q.sda_p & ~sda_f;
    assign stop       = scl_f & l_q.scl_p & ~l_q.sda_p & sda_f;

    always_comb
    begin
        l_d   = l_q;
        wr_en = 1'b0;
        upd   = 1'b0;
        chg   = 1'b0;
        word  = 16'h0000;
        l_d.scl_p = scl_f;
        l_d.sda_p = sda_f;
        if (l_q.init != `OPIS_INIT_DONE)
        begin
            l_d.init = l_q.init + 3'h1;
        end
        // Strap caught once its filter has settled
        if (l_q.init == `OPIS_INIT_LOAD)
        begin
            l_d.range = strap_f;
            upd       = 1'b1;
        end
        if (start)
        begin
            l_d.st     = ST_ADDR;
            l_d.bitc   = 4'h0;
            l_d.sda_oe = 1'b0;
            l_d.second = 1'b0;
        end
        else if (stop)
        begin
            l_d.st     = ST_IDLE;
            l_d.sda_oe = 1'b0;
        end
        else
        begin
            case (l_q.st)
                ST_ADDR, ST_REG, ST_WDAT:
                begin
                    if (scl_rise)
                    begin
                        l_d.shreg = {l_q.shreg[6:0], sda_f};
                        l_d.bitc  = l_q.bitc + 4'h1;
                    end
                    else if (scl_fall && l_q.bitc == `OPIS_BYTE_BITS)
                    begin
                        l_d.bitc   = 4'h0;
                        l_d.sda_oe = 1'b1;
                        case (l_q.st)
                            ST_ADDR:
                            begin
                                if (l_q.shreg[7:1] == DEV_ADDR)
                                begin
                                    l_d.dir_wr = l_q.shreg[0];
                                    l_d.st     = ST_AACK;
                                end
                                else
                                begin
                                    l_d.sda_oe = 1'b0;
                                    l_d.st     = ST_IDLE;
                                end
                            end
                            ST_REG:
                            begin
                                l_d.ptr    = l_q.shreg;
                                l_d.second = 1'b0;
                                l_d.st     = ST_RACK;
                            end
                            default:
                            begin
                                if (!l_q.second)
                                begin
                                    l_d.hi_byte = l_q.shreg;
                                end
                                else
                                begin
                                    wr_en = 1'b1;
                                end
                                l_d.second = ~l_q.second;
                                l_d.st     = ST_WACK;
                            end
                        endcase
                    end
                end
                ST_AACK:
                begin
                    if (scl_fall)
                    begin
                        l_d.sda_oe = 1'b0;
                        if (l_q.dir_wr)
                        begin
                            l_d.st = ST_REG;
                        end
                        else
                        begin
                            word       = rd_word(l_q, l_q.ptr);
                            l_d.shreg  = word[15:8];
                            l_d.sda_oe = ~word[15];
                            l_d.second = 1'b0;
                            l_d.st     = ST_RDAT;
                        end
                    end
                end
                ST_RACK, ST_WACK:
                begin
                    if (scl_fall)
                    begin
                        l_d.sda_oe = 1'b0;
                        l_d.st     = ST_WDAT;
                    end
                end
                ST_RDAT:
                begin
                    // Changes only after a falling clock edge
                    if (scl_fall)
                    begin
                        if (l_q.bitc == `OPIS_LAST_BIT)
                        begin
                            l_d.bitc   = 4'h0;
                            l_d.sda_oe = 1'b0;
                            l_d.st     = ST_MACK;
                        end
                        else
                        begin
                            l_d.bitc   = l_q.bitc + 4'h1;
                            l_d.shreg  = {l_q.shreg[6:0], 1'b0};
                            l_d.sda_oe = ~l_q.shreg[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        l_d.ack_seen = ~sda_f;
                    end
                    else if (scl_fall)
                    begin
                        if (l_q.second)
                        begin
                            l_d.ptr = l_q.ptr + `OPIS_PTR_STEP;
                        end
                        if (l_q.ack_seen)
                        begin
                            l_d.st = ST_IDLE;
                        end
                        else
                        begin
                            // Odd on purpose: a NACK asks for more data
                            if (!l_q.second)
                            begin
                                word      = rd_word(l_q, l_q.ptr);
                                l_d.shreg = word[7:0];
                            end
                            else
                            begin
                                word      = rd_word(l_q, l_q.ptr + `OPIS_PTR_STEP);
                                l_d.shreg = word[15:8];
                            end
                            l_d.second = ~l_q.second;
                            l_d.sda_oe = ~l_d.shreg[7];
                            l_d.st     = ST_RDAT;
                        end
                    end
                end
                default:
                begin
                    l_d.sda_oe = 1'b0;
                end
            endcase
        end
        if (wr_en)
        begin
            word = {l_q.hi_byte, l_q.shreg};
            case (l_q.ptr)
                `OPIS_REG_LOWER: l_d.lower = word;
                `OPIS_REG_UPPER:
                begin
                    l_d.upper = word[`OPIS_UPPER_MSB:0];
                    l_d.oe    = word[`OPIS_OE_BIT];
                    chg       = 1'b1;
                end
                `OPIS_REG_RANGE: l_d.range = word[`OPIS_RANGE_MSB:0];
                default:         l_d.range = l_q.range;
            endcase
            l_d.ptr = l_q.ptr + `OPIS_PTR_STEP;
            upd     = 1'b1;
        end
        // Snapshot stays put until the next write, many SCL bits away
        if (upd)
        begin
            l_d.snap_pull  = {l_d.upper, l_d.lower};
            l_d.snap_oe    = l_d.oe;
            l_d.snap_range = l_d.range;
            l_d.snap_chg   = chg;
            l_d.tog        = ~l_q.tog;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            l_q       <= '0;
            l_q.st    <= ST_IDLE;
            l_q.scl_p <= 1'b1;
            l_q.sda_p <= 1'b1;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    // Slave only: SCL never driven, SDA only pulled low
    assign sda_o  = 1'b0;
    assign sda_oe = l_q.sda_oe;

    a_sda_stable_high: assert property (@(posedge link_clk) disable iff (lrst)
        (scl_f && $past(scl_f)) |-> $stable(l_q.sda_oe))
        else $error("Data line moved while clock high");
    a_start_restart: assert property (@(posedge link_clk) disable iff (lrst)
        start |=> (l_q.st == ST_ADDR && l_q.bitc == 4'h0 && !l_q.sda_oe))
        else $error("START did not restart address phase");
    a_stop_idle: assert property (@(posedge link_clk) disable iff (lrst)
        (stop && !start) |=> (l_q.st == ST_IDLE && !l_q.sda_oe))
        else $error("STOP did not return to idle");
    a_addr_nack: assert property (@(posedge link_clk) disable iff (lrst)
        (l_q.st == ST_ADDR && scl_fall && l_q.bitc == `OPIS_BYTE_BITS && !start && !stop)
        |=> (l_q.sda_oe == (l_q.st == ST_AACK)) && ($past(l_q.shreg[7:1]) == DEV_ADDR)
            == (l_q.st == ST_AACK))
        else $error("Address acknowledge does not follow match");
    a_ack_drive: assert property (@(posedge link_clk) disable iff (lrst)
        (l_q.st inside {ST_AACK, ST_RACK, ST_WACK}) |-> l_q.sda_oe)
        else $error("Receiver not holding acknowledge");
    a_ptr_wrap: assert property (@(posedge link_clk) disable iff (lrst)
        (wr_en && !start && !stop) |=> l_q.ptr == $past(l_q.ptr) + `OPIS_PTR_STEP)
        else $error("Pointer did not advance");
    a_range_write: assert property (@(posedge link_clk) disable iff (lrst)
        (wr_en && l_q.ptr == `OPIS_REG_RANGE) |=> l_q.range == $past(l_q.shreg[3:0]))
        else $error("Range field not written");
    a_range_ro: assert property (@(posedge link_clk) disable iff (lrst)
        (l_q.st == ST_RDAT && l_q.bitc == 4'h0 && !l_q.second && l_q.ptr == `OPIS_REG_RANGE)
        |-> l_q.shreg == 8'h00)
        else $error("Range upper byte not read as zero");
    a_nack_next: assert property (@(posedge link_clk) disable iff (lrst)
        (l_q.st == ST_MACK && scl_fall && !l_q.ack_seen && !start && !stop)
        |=> (l_q.st == ST_RDAT && l_q.sda_oe == ~l_q.shreg[7]))
        else $error("NACK did not continue read");

    // Core domain
    opis_core_t c_q;
    opis_core_t c_d;
    logic [1:0] oe_pins;
    logic       evt;
    logic [12:0] age_q;

    opis_sync #(.W(2)) u_csync (
        .clk (clk),
        .rst (rst),
        .d   ({oe_hw_sel, oe_pin}),
        .q   (oe_pins)
    );

    assign evt = c_q.tog_s2 ^ c_q.tog_s3;

    always_comb
    begin
        c_d        = c_q;
        c_d.tog_s1 = l_q.tog;
        c_d.tog_s2 = c_q.tog_s1;
        c_d.tog_s3 = c_q.tog_s2;
        c_d.fchg   = 1'b0;
        if (c_q.settling)
        begin
            if (c_q.settle_cnt == 12'h000)
            begin
                c_d.settling = 1'b0;
            end
            else
            begin
                c_d.settle_cnt = c_q.settle_cnt - 12'h001;
            end
        end
        if (evt)
        begin
            c_d.oe_sw = l_q.snap_oe;
            c_d.range = l_q.snap_range;
            c_d.span  = span_of(l_q.snap_range);
            if (l_q.snap_chg)
            begin
                c_d.pend    = l_q.snap_pull;
                c_d.dly_act = 1'b1;
                c_d.dly_cnt = 12'(FDELAY_CYC - 1);
            end
        end
        else if (c_q.dly_act)
        begin
            if (c_q.dly_cnt == 12'h000)
            begin
                c_d.dly_act    = 1'b0;
                c_d.pull       = c_q.pend;
                c_d.fchg       = 1'b1;
                c_d.settling   = 1'b1;
                c_d.settle_cnt = 12'(SETTLE_CYC - 1);
            end
            else
            begin
                c_d.dly_cnt = c_q.dly_cnt - 12'h001;
            end
        end
        // Pin control overrides the software bit
        c_d.drv_en = oe_pins[1] ? oe_pins[0] : c_d.oe_sw;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            c_q      <= '0;
            c_q.span <= span_of(4'h0);
        end
        else
        begin
            c_q <= c_d;
        end
    end

    // Cycles since the last accepted upper-word update
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            age_q <= '1;
        end
        else if (evt && l_q.snap_chg)
        begin
            age_q <= 13'h0000;
        end
        else if (age_q != '1)
        begin
            age_q <= age_q + 13'h0001;
        end
    end

    a_freq_delay: assert property (@(posedge clk) disable iff (rst)
        c_q.fchg |-> age_q == 13'(FDELAY_CYC))
        else $error("Frequency change at wrong delay");
    a_settle_time: assert property (@(posedge clk) disable iff (rst)
        $fell(c_q.settling) |-> age_q == 13'(FDELAY_CYC + SETTLE_CYC))
        else $error("Settling window wrong length");

    assign pull_value_o  = c_q.pull;
    assign pull_range_o  = c_q.range;
    assign pull_span_o   = c_q.span;
    assign drv_enable_o  = c_q.drv_en;
    assign freq_change_o = c_q.fchg;
    assign settling_o    = c_q.settling;

endmodule // opis_slave

// [hw/opis_defines.svh]
// Constants for the pulled-oscillator serial register slave.
// Assumes inclusion by bare name from the package, the slave and the synchroniser.
`ifndef OPIS_DEFINES_SVH
`define OPIS_DEFINES_SVH

// Register map (8-bit pointer space)
`define OPIS_REG_LOWER      8'h00
`define OPIS_REG_UPPER      8'h01
`define OPIS_REG_RANGE      8'h02
`define OPIS_UPPER_MSB      9
`define OPIS_OE_BIT         10
`define OPIS_RANGE_MSB      3
`define OPIS_PTR_STEP       8'h01

// Serial framing
`define OPIS_BYTE_BITS      4'h8
`define OPIS_LAST_BIT       4'h7
`define OPIS_DEV_ADDR_DFLT  7'h60

// Strap capture after link reset release
`define OPIS_INIT_LOAD      3'h6
`define OPIS_INIT_DONE      3'h7

// Glitch filter length in samples of each synchroniser's own clock
`define OPIS_FILT_LEN       2

// Timing on the core clock
`define OPIS_CLK_MHZ        125
`define OPIS_FDELAY_US      22
`define OPIS_SETTLE_US      30
`define OPIS_FDELAY_CYC     (`OPIS_FDELAY_US * `OPIS_CLK_MHZ)
`define OPIS_SETTLE_CYC     (`OPIS_SETTLE_US * `OPIS_CLK_MHZ)
`define OPIS_CNT_W          12
`define OPIS_AGE_W          13

`endif

// [hw/opis_pkg.sv]
// Types shared by the pulled-oscillator serial register slave.
// Assumes opis_defines.svh is on the include path.
`include "opis_defines.svh"

package opis_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_REG,
        ST_RACK,
        ST_WDAT,
        ST_WACK,
        ST_RDAT,
        ST_MACK
    } opis_st_t;

    // Link-side state
    typedef struct packed {
        opis_st_t    st;
        logic [3:0]  bitc;
        logic [7:0]  shreg;
        logic        dir_wr;
        logic        second;
        logic        ack_seen;
        logic [7:0]  ptr;
        logic [7:0]  hi_byte;
        logic [15:0] lower;
        logic [9:0]  upper;
        logic        oe;
        logic [3:0]  range;
        logic        sda_oe;
        logic [2:0]  init;
        logic        scl_p;
        logic        sda_p;
        logic [25:0] snap_pull;
        logic        snap_oe;
        logic [3:0]  snap_range;
        logic        snap_chg;
        logic        tog;
    } opis_link_t;

    // Core-side state
    typedef struct packed {
        logic        tog_s1;
        logic        tog_s2;
        logic        tog_s3;
        logic [25:0] pend;
        logic [25:0] pull;
        logic        oe_sw;
        logic        drv_en;
        logic [3:0]  range;
        logic [13:0] span;
        logic        dly_act;
        logic [11:0] dly_cnt;
        logic        settling;
        logic [11:0] settle_cnt;
        logic        fchg;
    } opis_core_t;

endpackage

// [hw/opis_sync.sv]
// Two-flop synchroniser followed by a stability glitch filter.
// Assumes d comes from outside the clk domain; rst is synchronous.
`timescale 1ns/10ps
`include "opis_defines.svh"

module opis_sync
    import opis_pkg::*;
#(
    parameter int           W       = 2,
    parameter int           FILT    = `OPIS_FILT_LEN,
    parameter logic [W-1:0] RST_VAL = '0
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [3:0]   cnt;
        logic [W-1:0] q;
    } opis_sync_t;

    opis_sync_t s_q;
    opis_sync_t s_d;

    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // A sample must repeat FILT times before it is believed
        if (s_q.s2 != s_q.s3)
        begin
            s_d.cnt = 4'h0;
        end
        else if (s_q.cnt < 4'(FILT - 1))
        begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
        else
        begin
            s_d.q = s_q.s3;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, cnt: 4'h0, q: RST_VAL};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign q = s_q.q;

endmodule // opis_sync

// [dv/opis_mst.sv]
// Serial bus master model.
// Assumes a pulled-up data wire fed back on sda.
`timescale 1ns/10ps

module opis_mst (
    output logic     scl,
    output logic     sda_oe,
    input  wire logic sda
);
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // Long low phase so the slave's late change never lands in high
    task automatic bt(input logic b, output logic r);
        sda_oe = ~b;
        #500 scl = 1'b1;
        #500 r = sda;
        scl = 1'b0;
        #500;
    endtask
    task automatic st();
        sda_oe = 1'b0;
        #500 scl = 1'b1;
        #500 sda_oe = 1'b1;
        #500 scl = 1'b0;
        #500;
    endtask
    task automatic sp();
        sda_oe = 1'b1;
        #500 scl = 1'b1;
        #500 sda_oe = 1'b0;
        #500;
    endtask
    task automatic wb(input logic [7:0] v, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bt(v[i], r);
        bt(1'b1, a);
    endtask
    // Ack ends the read, nack asks for more
    task automatic rb(input logic n, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
        bt(n, r);
    endtask
endmodule // opis_mst

// [dv/tb.sv]
// Self-checking bench for the serial register slave.
// Assumes the master model owns scl; strap tied to 5.
`timescale 1ns/10ps

module tb;
    localparam int FD = 1000;
    logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1, hw_sel = 1'b0, pin = 1'b0;
    logic scl, m_oe, sda_oe, sda_o, fchg, settl, drv, a;
    logic [25:0] pval;
    logic [3:0]  prng;
    logic [13:0] span;
    logic [7:0]  v;
    int          n_errors = 0;
    int          samples_checked = 0;
    wire         sda = ~(sda_oe | m_oe);

    initial forever #4 clk = ~clk;
    initial #13 forever #40 link_clk = ~link_clk;

    opis_slave #(.FDELAY_CYC(FD), .SETTLE_CYC(30)) uut (.clk(clk), .rst(rst),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .range_strap(4'h5), .oe_hw_sel(hw_sel), .oe_pin(pin), .pull_value_o(pval),
        .pull_range_o(prng), .pull_span_o(span), .drv_enable_o(drv),
        .freq_change_o(fchg), .settling_o(settl));
    opis_mst m (.scl(scl), .sda_oe(m_oe), .sda(sda));

    task automatic chk(input logic [25:0] got, input logic [25:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] b);
        m.wb(b, a);
        chk(a, 0);
    endtask
    task automatic t_init();
        chk(prng, 5);
        chk(span, 14'h0140);
        chk(pval, 0);
        chk(drv, 0);
        chk(sda_o, 0);
    endtask
    task automatic t_nack();
        m.st();
        m.wb(8'hC3, a);
        chk(a, 1);
        m.sp();
    endtask
    // Pointer 0xFF wraps to reg 0
    task automatic t_lower();
        m.st();
        wr(8'hC1);
        wr(8'hFF);
        wr(8'h00);
        wr(8'h00);
        wr(8'h12);
        wr(8'h34);
        m.sp();
        cyc(FD + 50);
        chk(pval, 0);
    endtask
    task automatic t_upper();
        int k;
        m.st();
        wr(8'hC1);
        wr(8'h00);
        wr(8'h12);
        wr(8'h34);
        wr(8'hFF);
        wr(8'hFF);
        for (k = 0; k < 2000 && fchg !== 1'b1; k++) cyc(1);
        chk(k > FD - 250 && k <= FD, 1);
        if (k == 2000) end_of_test();
        for (k = 0; k < 100 && settl === 1'b1; k++) cyc(1);
        chk(k, 30);
        if (k == 100) end_of_test();
        chk(pval, {10'h3FF, 16'h1234});
        chk(drv, 1);
        wr(8'hFF);
        wr(8'hFF);
        m.sp();
        cyc(10);
        chk(prng, 4'hF);
        chk(span, 14'h3200);
    endtask
    task automatic t_read();
        logic [7:0] e [6] = '{8'h12, 8'h34, 8'h07, 8'hFF, 8'h00, 8'h0F};
        m.st();
        wr(8'hC1);
        wr(8'h00);
        m.st();
        wr(8'hC0);
        for (int i = 0; i < 6; i++)
        begin
            m.rb(i != 5, v);
            chk(v, e[i]);
        end
        m.sp();
        chk(sda_oe, 0);
    endtask
    task automatic t_pin();
        cyc(1);
        hw_sel = 1'b1;
        cyc(10);
        chk(drv, 0);
        pin = 1'b1;
        cyc(10);
        chk(drv, 1);
    endtask

    // Reset outlasts several link clocks so both domains see it
    initial
    begin
        cyc(64);
        rst = 1'b0;
        cyc(150);
        t_init();
        t_nack();
        t_lower();
        t_upper();
        t_read();
        t_pin();
        end_of_test();
    end
endmodule // tb
